// *** inc/ccs_pkg.sv ***
//--------------------------------------------------------------
// Common command and status store: shared constants and types
//--------------------------------------------------------------
package ccs_pkg;

	// Commands accepted on the command port
	typedef enum logic [3:0] {
		CMD_OPT_QUERY,
		CMD_PSC_SET,
		CMD_PSC_QUERY,
		CMD_SAVE,
		CMD_RECALL,
		CMD_RESET,
		CMD_DEV_CLEAR,
		CMD_SRE_SET,
		CMD_SRE_QUERY,
		CMD_ESE_SET,
		CMD_ESE_QUERY,
		CMD_ESR_READ,
		CMD_STB_READ,
		CMD_SERIAL_POLL,
		CMD_CFG_WRITE
	} ccs_cmd_t;

	// Controller states
	typedef enum logic [2:0] {
		ST_BOOT_A,
		ST_BOOT_B,
		ST_BOOT_LOAD,
		ST_IDLE,
		ST_OPT,
		ST_RCL
	} ccs_state_t;

	// Status byte bit positions
	localparam int STB_OPER = 7;
	localparam int STB_MSS  = 6;
	localparam int STB_ESB  = 5;
	localparam int STB_MAV  = 4;
	localparam int STB_QUES = 3;

	// Standard event bit positions, bits 6 and 1 unused
	localparam int ESR_PON = 7;
	localparam int ESR_CME = 5;
	localparam int ESR_EXE = 4;
	localparam int ESR_DDE = 3;
	localparam int ESR_QYE = 2;
	localparam int ESR_OPC = 0;
	localparam logic [7:0] ESR_EVT_MASK = 8'hBD;

	// Option list: revision in hundredths (1.13 -> 113)
	localparam int OPT_FIELDS = 14;
	localparam logic [15:0] OPT_MIN_REV [OPT_FIELDS] = '{
		16'h0000, 16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0000, 16'h0000, 16'h0000, 16'h0000,
		16'h0071,   // aero_profile_a_field, 1.13
		16'h0072,   // low_freq_limit_field, 1.14
		16'h0190,   // multibox_config_field, 4.00
		16'h0190,   // aero_profile_b_field, 4.00
		16'h0190    // aero_profile_c_field, 4.00
	};

	// Saved state slots
	localparam int SLOTS = 8;

	// Instrument state word layout
	localparam int ST_OUT_ON   = 0;
	localparam int ST_CONT     = 1;
	localparam int ST_TRIG_OUT = 2;
	localparam int ST_TRIG_SRC = 3;
	localparam int ST_SYNC_SRC = 5;
	localparam int ST_SLEW_MAX = 7;
	localparam int ST_PHASE    = 8;
	localparam int ST_OCP_DLY  = 17;
	localparam int ST_FREQ     = 33;
	localparam int SRC_W       = 2;
	localparam int PHASE_W     = 9;
	localparam int DLY_W       = 16;
	localparam int FREQ_W      = 15;
	localparam int STATE_W     = 48;

	// Reset defaults
	localparam logic [SRC_W-1:0]   SRC_IMM      = 2'h0;
	localparam logic [DLY_W-1:0]   OCP_DELAY_MS = 16'h0064;
	localparam logic [FREQ_W-1:0]  TRIG_FREQ_HZ = 15'h003C;
	localparam logic [PHASE_W-1:0] SYNC_PHASE   = 9'h000;
	localparam logic [STATE_W-1:0] RST_STATE    = {TRIG_FREQ_HZ, OCP_DELAY_MS, SYNC_PHASE,
		1'b1, SRC_IMM, SRC_IMM, 1'b0, 1'b0, 1'b0};

endpackage : ccs_pkg

// *** hdl/ccs_state_mem.sv ***
`timescale 1ns/1ps
//--------------------------------------------------------------
// Saved state slots, registered read
//--------------------------------------------------------------
module ccs_state_mem #(
	parameter int WIDTH = ccs_pkg::STATE_W,
	parameter int DEPTH = ccs_pkg::SLOTS
) (
	// Clock
	input  wire logic                     i_sys_clk,
	// Write port
	input  wire logic                     i_we,
	input  wire logic [$clog2(DEPTH)-1:0] i_waddr,
	input  wire logic [WIDTH-1:0]         i_wdata,
	// Read port
	input  wire logic                     i_re,
	input  wire logic [$clog2(DEPTH)-1:0] i_raddr,
	output logic      [WIDTH-1:0]         o_rdata
);

	// Slot storage; contents survive the block reset
	logic [WIDTH-1:0] mem [DEPTH];

	// Write and registered read
	always_ff @(posedge i_sys_clk) begin
		if (i_we) begin
			mem[i_waddr] <= i_wdata;
		end
		if (i_re) begin
			o_rdata <= mem[i_raddr];
		end
	end

endmodule : ccs_state_mem

// *** hdl/ccs_opt_list.sv ***
`timescale 1ns/1ps
//--------------------------------------------------------------
// Option list lookup
//--------------------------------------------------------------
module ccs_opt_list #(
	parameter int FIELDS = ccs_pkg::OPT_FIELDS
) (
	// Lookup
	input  wire logic [3:0]        i_idx,
	input  wire logic [15:0]       i_fw_rev,
	input  wire logic [FIELDS-1:0] i_installed,
	// Result
	output logic      [3:0]        o_code,
	output logic      [3:0]        o_count
);

	// Count of listed fields; gated fields sit at the tail with rising
	// revisions, so the listed ones always form a prefix
	always_comb begin
		o_count = 4'h0;
		for (int i = 0; i < FIELDS; i++) begin
			if (i_fw_rev >= ccs_pkg::OPT_MIN_REV[i]) begin
				o_count = 4'(o_count + 4'h1);
			end
		end
		// Field code is its position plus one, zero when absent
		o_code = 4'h0;
		if (int'(i_idx) < FIELDS && i_installed[i_idx]) begin
			o_code = 4'(i_idx + 4'h1);
		end
	end

endmodule : ccs_opt_list

// *** hdl/ccs_top.sv ***
`timescale 1ns/1ps
//--------------------------------------------------------------
// Common command and status store
//--------------------------------------------------------------
// Contract
// RULE_01: Option list fixed order, zero when absent
// RULE_02: Late fields dropped below their revision
// RULE_03: Power-on clear set clears both masks
// RULE_04: Power-on clear off restores stored masks
// RULE_05: Recall restores slot, calibration off, abort
// RULE_06: Save writes state into named slot
// RULE_07: Reset or device clear loads defaults
// RULE_08: Reset clears status, keeps enable masks
// RULE_09: Request mask gates status byte bit six
// RULE_10: Serial poll clears request, summary stays
// RULE_11: Zero request mask never requests service
// RULE_12: Controller toggles phase mode after reset; the controller has no phase mode and toggles nothing
// RULE_13: Status byte bit layout fixed
// RULE_14: Standard event bit layout fixed
// RULE_15: Event register read returns then clears
// RULE_16: Service request output follows request flag
module ccs_top (
	// Clock and reset
	input  wire logic                           i_sys_clk,
	input  wire logic                           i_rst_n,
	// Command port
	input  wire logic                           i_cmd_valid,
	input  wire ccs_pkg::ccs_cmd_t              i_cmd_code,
	input  wire logic [7:0]                     i_cmd_arg,
	input  wire logic [ccs_pkg::STATE_W-1:0]    i_cfg_state,
	output logic                                o_cmd_ready,
	output logic                                o_resp_valid,
	output logic      [7:0]                     o_resp_data,
	// Option list stream
	output logic                                o_opt_valid,
	output logic      [3:0]                     o_opt_code,
	output logic                                o_opt_last,
	// Status sources, same clock
	input  wire logic                           i_oper_sum,
	input  wire logic                           i_ques_sum,
	input  wire logic                           i_mav,
	input  wire logic                           i_evt_cme,
	input  wire logic                           i_evt_exe,
	input  wire logic                           i_evt_dde,
	input  wire logic                           i_evt_qye,
	input  wire logic                           i_evt_opc,
	// Nonvolatile and strap pins
	input  wire logic                           i_nv_psc,
	input  wire logic [7:0]                     i_nv_sre,
	input  wire logic [7:0]                     i_nv_ese,
	input  wire logic [15:0]                    i_fw_rev,
	input  wire logic [ccs_pkg::OPT_FIELDS-1:0] i_opt_installed,
	// Mask copies for nonvolatile storage
	output logic                                o_psc,
	output logic      [7:0]                     o_sre_mask,
	output logic      [7:0]                     o_ese_mask,
	// Status and service request
	output logic      [7:0]                     o_status_byte,
	output logic                                o_srq,
	// Instrument settings
	output logic                                o_output_on,
	output logic                                o_continuous_initiation,
	output logic                                o_trigger_output_enable,
	output logic      [ccs_pkg::SRC_W-1:0]      o_trigger_source_select,
	output logic      [ccs_pkg::SRC_W-1:0]      o_sync_source_select,
	output logic                                o_slew_max,
	output logic      [ccs_pkg::PHASE_W-1:0]    o_sync_phase_angle,
	output logic      [ccs_pkg::DLY_W-1:0]      o_overcurrent_trip_delay,
	output logic      [ccs_pkg::FREQ_W-1:0]     o_trig_frequency,
	// Recall side effects, one-cycle pulses
	output logic                                o_cal_off,
	output logic                                o_trig_abort
);

	//--------------------------------------------------------------
	// Reset release and pin synchronisers
	//--------------------------------------------------------------
	localparam int PIN_W = 1 + 8 + 8 + 16 + ccs_pkg::OPT_FIELDS;

	logic             rst_meta;   // First reset stage
	logic             rst_n_s;    // Released reset for the block
	logic [PIN_W-1:0] pin_meta;   // First pin stage
	logic [PIN_W-1:0] pin_sync;   // Pins safe to read

	// Assert at once, release after two edges
	always_ff @(posedge i_sys_clk or negedge i_rst_n) begin
		if (!i_rst_n) begin
			rst_meta <= 1'b0;
			rst_n_s  <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n_s  <= rst_meta;
		end
	end

	// Pins come from outside the clock domain
	always_ff @(posedge i_sys_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			pin_meta <= '0;
			pin_sync <= '0;
		end else begin
			pin_meta <= {i_nv_psc, i_nv_sre, i_nv_ese, i_fw_rev, i_opt_installed};
			pin_sync <= pin_meta;
		end
	end

	logic                           s_psc;
	logic [7:0]                     s_sre;
	logic [7:0]                     s_ese;
	logic [15:0]                    s_rev;
	logic [ccs_pkg::OPT_FIELDS-1:0] s_inst;
	assign {s_psc, s_sre, s_ese, s_rev, s_inst} = pin_sync;

	//--------------------------------------------------------------
	// Helpers
	//--------------------------------------------------------------
	ccs_pkg::ccs_state_t           state, next_state;
	logic [ccs_pkg::STATE_W-1:0]   cfg, next_cfg;       // Live settings
	logic [7:0]                    sre, next_sre;       // Request mask
	logic [7:0]                    ese, next_ese;       // Event mask
	logic                          psc, next_psc;       // Power-on clear
	logic [3:0]                    opt_idx, next_idx;   // Walk position
	logic [3:0]                    opt_code, opt_count;
	logic [ccs_pkg::STATE_W-1:0]   mem_rdata;
	logic                          mem_we, mem_re;
	logic                          next_opt_valid, next_opt_last, next_resp_valid;
	logic                          next_cal_off, next_trig_abort;
	logic [3:0]                    next_opt_code;
	logic [7:0]                    next_resp_data;
	logic                          evt_exe, clr_status, poll, esr_read, pon_evt;
	logic [7:0]                    esr, next_esr;       // Standard events
	logic                          rqs, next_rqs;       // Request for service
	logic                          mss_q;               // Summary, last cycle
	logic                          mss, esb;
	logic [7:0]                    stb_sum, ev, next_stb;
	logic                          slot_ok;

	assign o_cmd_ready = (state == ccs_pkg::ST_IDLE);
	assign slot_ok     = (int'(i_cmd_arg) < ccs_pkg::SLOTS);

	// RULE_06 save slots
	ccs_state_mem u_mem (
		.i_sys_clk (i_sys_clk),
		.i_we      (mem_we),
		.i_waddr   (i_cmd_arg[2:0]),
		.i_wdata   (cfg),
		.i_re      (mem_re),
		.i_raddr   (i_cmd_arg[2:0]),
		.o_rdata   (mem_rdata)
	);

	// RULE_02 revision gated list
	ccs_opt_list u_opt (
		.i_idx       (opt_idx),
		.i_fw_rev    (s_rev),
		.i_installed (s_inst),
		.o_code      (opt_code),
		.o_count     (opt_count)
	);

	//--------------------------------------------------------------
	// Command controller
	//--------------------------------------------------------------
	always_comb begin
		next_state = state;  next_cfg = cfg;  next_sre = sre;  next_ese = ese;
		next_psc = psc;  next_idx = opt_idx;  next_opt_code = o_opt_code;
		next_opt_valid = 1'b0;  next_opt_last = 1'b0;  next_resp_valid = 1'b0;
		next_resp_data = o_resp_data;  next_cal_off = 1'b0;  next_trig_abort = 1'b0;
		mem_we = 1'b0;  mem_re = 1'b0;  evt_exe = 1'b0;  clr_status = 1'b0;
		poll = 1'b0;  esr_read = 1'b0;  pon_evt = 1'b0;
		unique case (state)
			// Give the pin synchronisers time to fill
			ccs_pkg::ST_BOOT_A: next_state = ccs_pkg::ST_BOOT_B;
			ccs_pkg::ST_BOOT_B: next_state = ccs_pkg::ST_BOOT_LOAD;
			ccs_pkg::ST_BOOT_LOAD: begin
				next_psc = s_psc;
				pon_evt  = 1'b1;
				if (s_psc) begin
					// RULE_03 masks cleared
					next_sre = 8'h00;
					next_ese = 8'h00;
				end else begin
					// RULE_04 masks restored
					next_sre = s_sre;
					next_ese = s_ese;
				end
				next_state = ccs_pkg::ST_IDLE;
			end
			ccs_pkg::ST_IDLE: if (i_cmd_valid) begin
				unique case (i_cmd_code)
					ccs_pkg::CMD_OPT_QUERY: begin
						next_idx   = 4'h0;
						next_state = ccs_pkg::ST_OPT;
					end
					ccs_pkg::CMD_PSC_SET: next_psc = i_cmd_arg[0];
					ccs_pkg::CMD_PSC_QUERY: begin
						next_resp_valid = 1'b1;
						next_resp_data  = {7'h00, psc};
					end
					// RULE_09 any 8-bit value accepted
					ccs_pkg::CMD_SRE_SET: next_sre = i_cmd_arg;
					ccs_pkg::CMD_SRE_QUERY: begin
						next_resp_valid = 1'b1;
						next_resp_data  = sre;
					end
					ccs_pkg::CMD_ESE_SET: next_ese = i_cmd_arg;
					ccs_pkg::CMD_ESE_QUERY: begin
						next_resp_valid = 1'b1;
						next_resp_data  = ese;
					end
					// RULE_15 return then clear
					ccs_pkg::CMD_ESR_READ: begin
						next_resp_valid = 1'b1;
						next_resp_data  = esr;
						esr_read        = 1'b1;
					end
					ccs_pkg::CMD_STB_READ: begin
						next_resp_valid = 1'b1;
						next_resp_data  = next_stb;
					end
					// RULE_10 poll shows request flag in bit six
					ccs_pkg::CMD_SERIAL_POLL: begin
						next_resp_valid = 1'b1;
						next_resp_data  = stb_sum | {1'b0, rqs, 6'h00};
						poll            = 1'b1;
					end
					// RULE_06 slot out of range is an execution error
					ccs_pkg::CMD_SAVE: begin
						mem_we  = slot_ok;
						evt_exe = !slot_ok;
					end
					ccs_pkg::CMD_RECALL: begin
						mem_re  = slot_ok;
						evt_exe = !slot_ok;
						if (slot_ok) begin
							next_state = ccs_pkg::ST_RCL;
						end
					end
					// RULE_07 defaults; RULE_08 masks untouched
					ccs_pkg::CMD_RESET, ccs_pkg::CMD_DEV_CLEAR: begin
						next_cfg   = ccs_pkg::RST_STATE;
						clr_status = 1'b1;
					end
					ccs_pkg::CMD_CFG_WRITE: next_cfg = i_cfg_state;
					default: ;
				endcase
			end
			// RULE_01 one field per cycle, zero when absent
			ccs_pkg::ST_OPT: begin
				next_opt_valid = 1'b1;
				next_opt_code  = opt_code;
				next_opt_last  = (opt_idx == 4'(opt_count - 4'h1));
				next_idx       = 4'(opt_idx + 4'h1);
				if (next_opt_last) begin
					next_state = ccs_pkg::ST_IDLE;
				end
			end
			// RULE_05 restore, calibration off, trigger abort
			ccs_pkg::ST_RCL: begin
				next_cfg        = mem_rdata;
				next_cal_off    = 1'b1;
				next_trig_abort = 1'b1;
				next_state      = ccs_pkg::ST_IDLE;
			end
		endcase
	end

	// Controller registers
	always_ff @(posedge i_sys_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			state <= ccs_pkg::ST_BOOT_A;  cfg <= ccs_pkg::RST_STATE;
			sre <= 8'h00;  ese <= 8'h00;  psc <= 1'b1;  opt_idx <= 4'h0;
			o_opt_valid <= 1'b0;  o_opt_code <= 4'h0;  o_opt_last <= 1'b0;
			o_resp_valid <= 1'b0;  o_resp_data <= 8'h00;
			o_cal_off <= 1'b0;  o_trig_abort <= 1'b0;
		end else begin
			state <= next_state;  cfg <= next_cfg;
			sre <= next_sre;  ese <= next_ese;  psc <= next_psc;  opt_idx <= next_idx;
			o_opt_valid <= next_opt_valid;  o_opt_code <= next_opt_code;
			o_opt_last <= next_opt_last;
			o_resp_valid <= next_resp_valid;  o_resp_data <= next_resp_data;
			o_cal_off <= next_cal_off;  o_trig_abort <= next_trig_abort;
		end
	end

	//--------------------------------------------------------------
	// Status byte and service request
	//--------------------------------------------------------------
	always_comb begin
		// RULE_14 event layout, unused bits masked
		ev = 8'h00;
		ev[ccs_pkg::ESR_PON] = pon_evt;
		ev[ccs_pkg::ESR_CME] = i_evt_cme;
		ev[ccs_pkg::ESR_EXE] = i_evt_exe | evt_exe;
		ev[ccs_pkg::ESR_DDE] = i_evt_dde;
		ev[ccs_pkg::ESR_QYE] = i_evt_qye;
		ev[ccs_pkg::ESR_OPC] = i_evt_opc;
		ev = ev & ccs_pkg::ESR_EVT_MASK;
		// Arriving events survive a clear in the same cycle
		next_esr = ((esr_read || clr_status) ? 8'h00 : esr) | ev;
		esb = |(esr & ese);
		// RULE_13 status byte layout
		stb_sum = 8'h00;
		stb_sum[ccs_pkg::STB_OPER] = i_oper_sum;
		stb_sum[ccs_pkg::STB_ESB]  = esb;
		stb_sum[ccs_pkg::STB_MAV]  = i_mav;
		stb_sum[ccs_pkg::STB_QUES] = i_ques_sum;
		// RULE_09 masked summary; RULE_11 zero mask gives none
		mss = |(stb_sum & sre);
		next_stb = stb_sum;
		next_stb[ccs_pkg::STB_MSS] = mss;
		// RULE_10 a new request wins over a poll
		next_rqs = (mss && !mss_q) || (rqs && !(poll || clr_status));
	end

	// Status registers
	always_ff @(posedge i_sys_clk or negedge rst_n_s) begin
		if (!rst_n_s) begin
			esr <= 8'h00;  rqs <= 1'b0;  mss_q <= 1'b0;  o_status_byte <= 8'h00;
		end else begin
			esr <= next_esr;  rqs <= next_rqs;  mss_q <= mss;  o_status_byte <= next_stb;
		end
	end

	// RULE_16 request drives the line until polled, reset or device clear
	assign o_srq = rqs;

	//--------------------------------------------------------------
	// Setting outputs
	//--------------------------------------------------------------
	assign o_psc                    = psc;
	assign o_sre_mask               = sre;
	assign o_ese_mask               = ese;
	assign o_output_on              = cfg[ccs_pkg::ST_OUT_ON];
	assign o_continuous_initiation  = cfg[ccs_pkg::ST_CONT];
	assign o_trigger_output_enable  = cfg[ccs_pkg::ST_TRIG_OUT];
	assign o_trigger_source_select  = cfg[ccs_pkg::ST_TRIG_SRC +: ccs_pkg::SRC_W];
	assign o_sync_source_select     = cfg[ccs_pkg::ST_SYNC_SRC +: ccs_pkg::SRC_W];
	assign o_slew_max               = cfg[ccs_pkg::ST_SLEW_MAX];
	assign o_sync_phase_angle       = cfg[ccs_pkg::ST_PHASE +: ccs_pkg::PHASE_W];
	assign o_overcurrent_trip_delay = cfg[ccs_pkg::ST_OCP_DLY +: ccs_pkg::DLY_W];
	assign o_trig_frequency         = cfg[ccs_pkg::ST_FREQ +: ccs_pkg::FREQ_W];

	//--------------------------------------------------------------
	// Checks
	//--------------------------------------------------------------
	default clocking cb @(posedge i_sys_clk); endclocking
	default disable iff (!rst_n_s);

	logic go;
	assign go = i_cmd_valid && o_cmd_ready;

	a_opt_start: assert property (go && i_cmd_code == ccs_pkg::CMD_OPT_QUERY |-> ##2 o_opt_valid) // RULE_01
		else $error("option list did not start");
	a_opt_rev_gate: assert property (o_opt_valid |-> $past(opt_idx) < $past(opt_count)) // RULE_02
		else $error("option field emitted past revision limit");
	a_boot_clear: assert property (state == ccs_pkg::ST_BOOT_LOAD && s_psc |=> sre == 8'h00 && ese == 8'h00) // RULE_03
		else $error("masks not cleared at power-up");
	a_boot_restore: assert property (state == ccs_pkg::ST_BOOT_LOAD && !s_psc // RULE_04
		|=> sre == $past(s_sre) && ese == $past(s_ese))
		else $error("masks not restored at power-up");
	a_recall_effects: assert property (go && i_cmd_code == ccs_pkg::CMD_RECALL && slot_ok // RULE_05
		|-> ##2 o_cal_off && o_trig_abort && cfg == $past(mem_rdata))
		else $error("recall side effects missing");
	// Check the slot contents, not just the write strobe
	a_save_write: assert property (go && i_cmd_code == ccs_pkg::CMD_SAVE && slot_ok // RULE_06
		|=> u_mem.mem[$past(i_cmd_arg[2:0])] == $past(cfg))
		else $error("save did not write slot");
	a_reset_defaults: assert property (go && i_cmd_code inside {ccs_pkg::CMD_RESET, ccs_pkg::CMD_DEV_CLEAR} // RULE_07
		|=> cfg == ccs_pkg::RST_STATE)
		else $error("reset defaults not loaded");
	a_reset_masks: assert property (go && i_cmd_code == ccs_pkg::CMD_RESET // RULE_08
		|=> $stable(sre) && $stable(ese) && esr == $past(ev))
		else $error("reset disturbed masks or kept events");
	a_mss_bit: assert property (o_status_byte[ccs_pkg::STB_MSS] == |($past(stb_sum) & $past(sre))) // RULE_09
		else $error("summary bit mismatch");
	a_poll_clear: assert property (go && i_cmd_code == ccs_pkg::CMD_SERIAL_POLL && !(mss && !mss_q) |=> !o_srq) // RULE_10
		else $error("poll did not clear request");
	a_zero_mask: assert property (sre == 8'h00 |=> !$rose(o_srq)) // RULE_11
		else $error("request raised with zero mask");
	// The byte is held clear through reset, so skip the source compare on the first edge out
	a_stb_layout: assert property (o_status_byte[2:0] == 3'h0 && // RULE_13
		(!$past(rst_n_s) || o_status_byte[ccs_pkg::STB_OPER] == $past(i_oper_sum)))
		else $error("status byte layout wrong");
	a_esr_unused: assert property (esr[6] == 1'b0 && esr[1] == 1'b0) // RULE_14
		else $error("unused event bit set");
	a_esr_read: assert property (go && i_cmd_code == ccs_pkg::CMD_ESR_READ // RULE_15
		|=> o_resp_valid && o_resp_data == $past(esr) && esr == $past(ev))
		else $error("event read did not return and clear");
	a_srq_cause: assert property ($rose(o_srq) |-> $past(mss) && !$past(mss_q)) // RULE_16
		else $error("request without rising summary");

	c_opt_walk: cover property (o_opt_valid && o_opt_last);
	c_recall:   cover property (o_cal_off);
	c_srq_poll: cover property (o_srq ##[1:20] !o_srq);
	c_esr_read: cover property (go && i_cmd_code == ccs_pkg::CMD_ESR_READ && esr != 8'h00);

endmodule : ccs_top

// *** test/ccs_host_model.sv ***
`timescale 1ns/1ps
// Remote controller: issues one command at a time on the command port
module ccs_host_model (
	// Clock
	input  wire logic        i_sys_clk,
	// Answers from the device
	input  wire logic        i_ready,
	input  wire logic [7:0]  i_resp_data,
	// Command request
	output logic             o_valid,
	output ccs_pkg::ccs_cmd_t o_code,
	output logic      [7:0]  o_arg
);
	logic [7:0] last_resp; // Answer byte captured after the take
	initial begin
		o_valid = 1'b0;
		o_code = ccs_pkg::CMD_STB_READ;
		o_arg = 8'h00;
	end
	// phase reinit: the device has no phase port, nothing to toggle
	task automatic send(input ccs_pkg::ccs_cmd_t c, input logic [7:0] a);
		int n;
		n = 0;
		@(posedge i_sys_clk);
		#1;
		o_valid = 1'b1;
		o_code = c;
		o_arg = a;
		// Hold the request until an edge sees ready high; bounded
		do begin
			@(posedge i_sys_clk);
			n++;
		end while (i_ready !== 1'b1 && n < 50);
		#1;
		o_valid = 1'b0;
		// Argument is not held after the take, so show a changed value
		o_arg = ~a;
		last_resp = i_resp_data;
	endtask : send
endmodule : ccs_host_model

// *** test/tb_top.sv ***
`timescale 1ns/1ps
module tb_top;
	logic i_sys_clk, i_rst_n, i_cmd_valid, o_cmd_ready, o_resp_valid, o_opt_valid, o_opt_last, o_psc, o_srq;
	logic i_oper_sum, i_ques_sum, i_mav, i_evt_cme, i_evt_exe, i_evt_dde, i_evt_qye, i_evt_opc, i_nv_psc;
	logic o_output_on, o_continuous_initiation, o_trigger_output_enable, o_slew_max, o_cal_off, o_trig_abort;
	ccs_pkg::ccs_cmd_t i_cmd_code;
	logic [7:0] i_cmd_arg, o_resp_data, i_nv_sre, i_nv_ese, o_sre_mask, o_ese_mask, o_status_byte;
	logic [3:0] o_opt_code;
	logic [15:0] i_fw_rev, o_overcurrent_trip_delay;
	logic [13:0] i_opt_installed;
	logic [1:0] o_trigger_source_select, o_sync_source_select;
	logic [8:0] o_sync_phase_angle;
	logic [14:0] o_trig_frequency;
	logic [47:0] i_cfg_state, sett;
	int fails, n_checks, cnt;
	// Settings word rebuilt from the slices in package layout
	assign sett = {o_trig_frequency, o_overcurrent_trip_delay, o_sync_phase_angle, o_slew_max,
		o_sync_source_select, o_trigger_source_select, o_trigger_output_enable, o_continuous_initiation, o_output_on};
	ccs_top dut (.*);
	ccs_host_model host (.i_sys_clk(i_sys_clk), .i_ready(o_cmd_ready), .i_resp_data(o_resp_data),
		.o_valid(i_cmd_valid), .o_code(i_cmd_code), .o_arg(i_cmd_arg));
	// Ordinary command rows: code, argument, answer expected, answer
	typedef struct { ccs_pkg::ccs_cmd_t c; logic [7:0] a; bit q; logic [7:0] e; } row_t;
	row_t rows [6] = '{'{ccs_pkg::CMD_SRE_SET, 8'hA5, 0, 8'h00}, '{ccs_pkg::CMD_SRE_QUERY, 8'h00, 1, 8'hA5},
		'{ccs_pkg::CMD_ESE_SET, 8'h3C, 0, 8'h00}, '{ccs_pkg::CMD_ESE_QUERY, 8'h00, 1, 8'h3C},
		'{ccs_pkg::CMD_PSC_SET, 8'h00, 0, 8'h00}, '{ccs_pkg::CMD_PSC_QUERY, 8'h00, 1, 8'h00}};
	localparam logic [47:0] PAT = {15'h0032, 16'h00C8, 9'h05A, 1'b0, 2'h1, 2'h2, 3'b111};
	initial begin
		i_sys_clk = 1'b0;
		forever #2.5 i_sys_clk = ~i_sys_clk;
	end
	task automatic chk(input logic [47:0] got, input logic [47:0] exp);
		n_checks++;
		if (got !== exp) begin
			fails++;
			$display("BAD t=%0t got %0h want %0h", $time, got, exp);
		end
	endtask : chk
	// Reset with the given power-on clear pin, then wait for ready
	task automatic rst(input logic psc);
		i_nv_psc = psc;
		i_rst_n = 1'b0;
		repeat (4) @(posedge i_sys_clk);
		#1;
		i_rst_n = 1'b1;
		for (int k = 0; k < 40 && o_cmd_ready !== 1'b1; k++) @(posedge i_sys_clk);
	endtask : rst
	task automatic summarize;
		$display("checks %0d fails %0d", n_checks, fails);
		if (fails == 0 && n_checks > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask : summarize
	// Watchdog sized well beyond the fewer than 100 cycles the tests need
	initial begin
		#50000;
		fails++;
		summarize();
	end
	initial begin
		{fails, n_checks, i_oper_sum, i_ques_sum, i_mav, i_evt_cme, i_evt_exe, i_evt_dde, i_evt_qye, i_evt_opc} = 0;
		{i_nv_sre, i_nv_ese, i_fw_rev, i_opt_installed, i_cfg_state} = {8'h55, 8'hAA, 16'h0071, 14'h3FFD, PAT};
		rst(1'b1);
		chk({o_psc, o_sre_mask, o_ese_mask}, {1'b1, 16'h0000});
		chk(sett, ccs_pkg::RST_STATE);
		host.send(ccs_pkg::CMD_ESR_READ, 8'h00);
		chk(host.last_resp, 8'h80);
		host.send(ccs_pkg::CMD_ESR_READ, 8'h00);
		chk(host.last_resp, 8'h00);
		$display("boot test done");
		foreach (rows[i]) begin
			host.send(rows[i].c, rows[i].a);
			chk(o_resp_valid, rows[i].q);
			if (rows[i].q) chk(host.last_resp, rows[i].e);
		end
		$display("row test done");
		host.send(ccs_pkg::CMD_SRE_SET, 8'h10);
		i_mav = 1'b1;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk({o_status_byte[6], o_srq}, 2'b11);
		host.send(ccs_pkg::CMD_STB_READ, 8'h00);
		chk(host.last_resp, 8'h50);
		host.send(ccs_pkg::CMD_SERIAL_POLL, 8'h00);
		chk(host.last_resp[6], 1'b1);
		repeat (2) @(posedge i_sys_clk);
		#1;
		chk({o_status_byte[6], o_srq}, 2'b10);
		host.send(ccs_pkg::CMD_SRE_SET, 8'h00);
		{i_mav, i_oper_sum, i_ques_sum} = 3'b011;
		repeat (3) @(posedge i_sys_clk);
		#1;
		chk({o_status_byte, o_srq}, 9'h110);
		$display("request test done");
		host.send(ccs_pkg::CMD_CFG_WRITE, 8'h00);
		host.send(ccs_pkg::CMD_SAVE, 8'h03);
		host.send(ccs_pkg::CMD_SAVE, 8'h09);
		i_evt_cme = 1'b1;
		@(posedge i_sys_clk);
		#1;
		i_evt_cme = 1'b0;
		host.send(ccs_pkg::CMD_SRE_SET, 8'h30);
		host.send(ccs_pkg::CMD_RESET, 8'h00);
		chk(sett, ccs_pkg::RST_STATE);
		chk(o_sre_mask, 8'h30);
		chk(o_srq, 1'b0);
		host.send(ccs_pkg::CMD_ESR_READ, 8'h00);
		chk(host.last_resp, 8'h00);
		host.send(ccs_pkg::CMD_RECALL, 8'h03);
		chk(o_cmd_ready, 1'b0);
		@(posedge i_sys_clk);
		#1;
		chk({o_cal_off, o_trig_abort}, 2'b11);
		chk(sett, PAT);
		host.send(ccs_pkg::CMD_DEV_CLEAR, 8'h00);
		chk(sett, ccs_pkg::RST_STATE);
		$display("save test done");
		host.send(ccs_pkg::CMD_OPT_QUERY, 8'h00);
		cnt = 0;
		for (int k = 0; k < 30; k++) begin
			@(posedge i_sys_clk);
			#1;
			if (o_opt_valid === 1'b1) begin
				chk(o_opt_code, (cnt == 1) ? 4'h0 : 4'(cnt + 1));
				cnt++;
				if (o_opt_last === 1'b1) break;
			end
		end
		chk(cnt, 10);
		$display("option test done");
		rst(1'b0);
		chk({o_psc, o_sre_mask, o_ese_mask}, {1'b0, 16'h55AA});
		$display("restore test done");
		summarize();
	end
endmodule : tb_top
